// File: verilog/drt_timer_block.sv
`timescale 1ns/1ps
module drt_timer_block #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic instr_tick,
    input wire logic [3:0] acc_in,
    input wire logic [7:0] ab_in,
    input wire logic write_prescaler_ctrl_op,
    input wire logic write_second_ctrl_op,
    input wire logic write_pin_ctrl_op,
    input wire logic write_ext_edge_op,
    input wire logic read_prescaler_ctrl_op,
    input wire logic read_second_ctrl_op,
    input wire logic read_pin_ctrl_op,
    input wire logic load_first_timer_op,
    input wire logic load_first_reload_op,
    input wire logic read_first_timer_op,
    input wire logic load_second_timer_op,
    input wire logic read_second_timer_op,
    input wire logic skip_on_first_flag_op,
    input wire logic skip_on_second_flag_op,
    input wire logic [1:0] irq_select_control,
    input wire logic first_irq_accept,
    input wire logic second_irq_accept,
    input wire logic ext_int_pin,
    input wire logic counter_pin_in,
    output logic counter_pin_out,
    output logic counter_pin_oe,
    output logic [3:0] acc_out,
    output logic [7:0] ab_out,
    output logic skip_taken,
    output logic first_timer_irq_flag,
    output logic second_timer_irq_flag,
    output logic prescaler_out_clk
);
    import drt_pkg::*;

    if (WIDTH != 8) begin : g_width_check
        $error("drt_timer_block: only 8-bit timers are served");
    end

    // -----------------------------
    // control registers
    // -----------------------------
    logic [3:0] ptc_r;
    logic [3:0] t2c_r;
    logic [3:0] cpc_r;
    logic [3:0] epe_r;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ptc_r <= CTRL_RESET;
            t2c_r <= CTRL_RESET;
            cpc_r <= CTRL_RESET;
            epe_r <= CTRL_RESET;
        end else begin
            if (write_prescaler_ctrl_op) ptc_r <= acc_in;
            if (write_second_ctrl_op) t2c_r <= acc_in;
            if (write_pin_ctrl_op) cpc_r <= acc_in;
            if (write_ext_edge_op) epe_r <= acc_in;
        end
    end

    wire pre_run = ptc_r[PTC_PRE_RUN_BIT];
    wire pre_ratio = ptc_r[PTC_RATIO_BIT];
    wire t1_run = ptc_r[PTC_T1_RUN_BIT];
    wire sync_sel = ptc_r[PTC_SYNC_SEL_BIT];
    wire t2_run = t2c_r[T2C_RUN_BIT];
    wire auto_stop_select = t2c_r[T2C_AUTO_STOP_BIT];
    wire [1:0] t2_src = t2c_r[T2C_SRC_LO_BIT +: 2];
    wire pin_out_mode = cpc_r[CPC_FUNC_BIT];
    wire pin_out_sel = cpc_r[CPC_OUT_SEL_BIT];
    wire ext_pin_ctrl_enable = epe_r[EPE_ENABLE_BIT];
    wire ext_both_edge_select = epe_r[EPE_BOTH_BIT];
    wire ext_edge_polarity = epe_r[EPE_POL_BIT];

    // -----------------------------
    // pin synchronisers and edges
    // -----------------------------
    logic int_meta_r;
    logic int_sync_r;
    logic int_prev_r;
    logic cnt_meta_r;
    logic cnt_sync_r;
    logic cnt_prev_r;

    // two flops, then a delayed copy for edge detection
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            int_meta_r <= 1'b0;
            int_sync_r <= 1'b0;
            int_prev_r <= 1'b0;
            cnt_meta_r <= 1'b1;
            cnt_sync_r <= 1'b1;
            cnt_prev_r <= 1'b1;
        end else begin
            int_meta_r <= ext_int_pin;
            int_sync_r <= int_meta_r;
            int_prev_r <= int_sync_r;
            cnt_meta_r <= counter_pin_in;
            cnt_sync_r <= cnt_meta_r;
            cnt_prev_r <= cnt_sync_r;
        end
    end

    // int chain resets low: a false rise after reset cannot arm, enable resets to 0
    wire int_rise = int_sync_r && !int_prev_r;
    wire int_fall = !int_sync_r && int_prev_r;
    wire cnt_fall = !cnt_sync_r && cnt_prev_r;

    // edge selection for arming
    wire arm_edge = ext_both_edge_select ? (int_rise || int_fall) :
                    (ext_edge_polarity ? int_rise : int_fall);

    // -----------------------------
    // prescaler
    // -----------------------------
    logic [3:0] pre_cnt_r;
    logic pre_clk_r;
    // divide by 4 or 16, instruction ticks counted
    wire [3:0] pre_last = pre_ratio ? 4'(PRE_DIV_HIGH - 1) : 4'(PRE_DIV_LOW - 1);
    wire pre_wrap = pre_run && instr_tick && (pre_cnt_r >= pre_last);
    wire pre_tick = pre_wrap; // one pulse per prescaler period

    // run bit clear resets state and forces output low
    always_ff @(posedge sys_clk) begin
        if (rst || !pre_run) begin
            pre_cnt_r <= 4'h0;
            pre_clk_r <= 1'b0;
        end else if (instr_tick) begin
            pre_cnt_r <= pre_wrap ? 4'h0 : pre_cnt_r + 4'h1;
            if (pre_cnt_r == {1'b0, pre_last[3:1]} || pre_wrap) begin
                pre_clk_r <= pre_wrap; // rises at wrap, falls mid-period
            end
        end
    end

    // -----------------------------
    // count start synchronous circuit
    // -----------------------------
    logic armed_r;
    wire t1_uf;
    wire t2_uf;
    wire auto_stop = sync_sel && auto_stop_select && t1_uf;

    // arm on valid edge; clear on enable low or auto-stop
    always_ff @(posedge sys_clk) begin
        if (rst || !ext_pin_ctrl_enable) begin
            armed_r <= 1'b0;
        end else if (auto_stop) begin
            armed_r <= 1'b0;
        end else if (sync_sel && arm_edge) begin
            armed_r <= 1'b1;
        end
    end

    // gate source when the circuit is selected
    wire gate_ok = !(sync_sel && ext_pin_ctrl_enable) || armed_r;

    // -----------------------------
    // timers
    // -----------------------------
    wire t1_tick = pre_tick && gate_ok; // first source edge starts count
    logic t2_src_tick;
    // timer 2 source mux
    always_comb begin
        case (drt_src_t'(t2_src))
            DRT_SRC_T1_UF: t2_src_tick = t1_uf;
            DRT_SRC_PRESCALER: t2_src_tick = pre_tick;
            DRT_SRC_PIN: t2_src_tick = cnt_fall;
            DRT_SRC_SYSCLK: t2_src_tick = instr_tick;
            default: t2_src_tick = 1'b0;
        endcase
    end
    wire t2_tick = t2_src_tick && gate_ok;

    wire [7:0] t1_count;
    wire [7:0] t2_count;

    drt_down_timer #(.WIDTH(8)) u_t1 (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(t1_run),
        .tick(t1_tick),
        .load_both(load_first_timer_op),
        .load_reload(load_first_reload_op),
        .load_value(ab_in),
        .count(t1_count),
        .underflow(t1_uf)
    );

    drt_down_timer #(.WIDTH(8)) u_t2 (
        .sys_clk(sys_clk),
        .rst(rst),
        .run(t2_run),
        .tick(t2_tick),
        .load_both(load_second_timer_op),
        .load_reload(1'b0),
        .load_value(ab_in),
        .count(t2_count),
        .underflow(t2_uf)
    );

    // -----------------------------
    // request flags
    // -----------------------------
    logic t1f_r;
    logic t2f_r;
    // skip mode per bit of select control: 1 skip, 0 interrupt
    wire t1_skip_clr = irq_select_control[0] && skip_on_first_flag_op && t1f_r;
    wire t2_skip_clr = irq_select_control[1] && skip_on_second_flag_op && t2f_r;
    wire t1_clr = t1_skip_clr || (!irq_select_control[0] && first_irq_accept);
    wire t2_clr = t2_skip_clr || (!irq_select_control[1] && second_irq_accept);

    // set wins over clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            t1f_r <= 1'b0;
            t2f_r <= 1'b0;
        end else begin
            t1f_r <= t1_uf || (t1f_r && !t1_clr);
            t2f_r <= t2_uf || (t2f_r && !t2_clr);
        end
    end

    // -----------------------------
    // counter pin output, divide by 2
    // -----------------------------
    logic pin_tog_r;
    logic pin_oe_r;
    wire pin_uf = pin_out_sel ? t2_uf : t1_uf;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_tog_r <= 1'b0;
            pin_oe_r <= 1'b0;
        end else begin
            if (pin_uf) pin_tog_r <= !pin_tog_r;
            pin_oe_r <= pin_out_mode;
        end
    end

    // -----------------------------
    // read-back registers
    // -----------------------------
    logic [3:0] acc_r;
    logic [7:0] ab_r;
    logic skip_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            acc_r <= CTRL_RESET;
            ab_r <= TIMER_RESET;
            skip_r <= 1'b0;
        end else begin
            if (read_prescaler_ctrl_op) acc_r <= ptc_r;
            else if (read_second_ctrl_op) acc_r <= t2c_r;
            else if (read_pin_ctrl_op) acc_r <= cpc_r;
            if (read_first_timer_op) ab_r <= t1_count;
            else if (read_second_timer_op) ab_r <= t2_count;
            skip_r <= t1_skip_clr || t2_skip_clr;
        end
    end

    assign acc_out = acc_r;
    assign ab_out = ab_r;
    assign skip_taken = skip_r;
    assign first_timer_irq_flag = t1f_r;
    assign second_timer_irq_flag = t2f_r;
    assign prescaler_out_clk = pre_clk_r;
    assign counter_pin_out = pin_tog_r;
    assign counter_pin_oe = pin_oe_r;

    // -----------------------------
    // checks
    // -----------------------------
    chk_flag_set_uf: assert property (@(posedge sys_clk) disable iff (rst)
        t1_uf |=> t1f_r)
        else $error("timer 1 flag not set");
    chk_flag_t2_set: assert property (@(posedge sys_clk) disable iff (rst)
        t2_uf |=> t2f_r)
        else $error("timer 2 flag not set");
    chk_flag_skip_clear: assert property (@(posedge sys_clk) disable iff (rst)
        t1_skip_clr && !t1_uf |=> !t1f_r)
        else $error("skip did not clear flag");
    chk_pre_stop_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !pre_run |=> !pre_clk_r && pre_cnt_r == 4'h0)
        else $error("prescaler not initialised when stopped");
    // wrap points held against the package counts, not against the ratio mux
    chk_pre_div_four: assert property (@(posedge sys_clk) disable iff (rst)
        pre_tick && !pre_ratio |-> pre_cnt_r == 4'(PRE_DIV_LOW - 1))
        else $error("prescaler divide by 4 wrapped at wrong count");
    chk_pre_div_sixteen: assert property (@(posedge sys_clk) disable iff (rst)
        pre_tick && pre_ratio |-> pre_cnt_r == 4'(PRE_DIV_HIGH - 1))
        else $error("prescaler divide by 16 wrapped at wrong count");
    chk_auto_stop_disarm: assert property (@(posedge sys_clk) disable iff (rst)
        auto_stop |=> !armed_r)
        else $error("auto-stop did not disarm");
    chk_armed_enable_low: assert property (@(posedge sys_clk) disable iff (rst)
        !ext_pin_ctrl_enable |=> !armed_r)
        else $error("circuit armed while enable low");
    chk_gate_blocks: assert property (@(posedge sys_clk) disable iff (rst)
        sync_sel && ext_pin_ctrl_enable && !armed_r |-> !t1_tick)
        else $error("count passed while not armed");
    chk_pin_fall_tick: assert property (@(posedge sys_clk) disable iff (rst)
        t2_src == 2'b10 && t2_tick |->
            $past(counter_pin_in, 3) && !$past(counter_pin_in, 2))
        else $error("pin source ticked without falling edge");
    chk_pin_toggle: assert property (@(posedge sys_clk) disable iff (rst)
        pin_uf |=> pin_tog_r != $past(pin_tog_r))
        else $error("pin output did not toggle");
    cov_t1_uf: cover property (@(posedge sys_clk) disable iff (rst) t1_uf);
    cov_auto_stop: cover property (@(posedge sys_clk) disable iff (rst) auto_stop);
    cov_pin_src: cover property (@(posedge sys_clk) disable iff (rst) t2_src == 2'b10 && t2_uf);
    cov_div16: cover property (@(posedge sys_clk) disable iff (rst) pre_tick && pre_ratio);
endmodule : drt_timer_block

// File: verilog/drt_pkg.sv
package drt_pkg;
    // -----------------------------
    // control field positions
    // -----------------------------
    localparam int PTC_SYNC_SEL_BIT = 0;
    localparam int PTC_T1_RUN_BIT = 1;
    localparam int PTC_RATIO_BIT = 2;
    localparam int PTC_PRE_RUN_BIT = 3;
    localparam int T2C_SRC_LO_BIT = 0;
    localparam int T2C_AUTO_STOP_BIT = 2;
    localparam int T2C_RUN_BIT = 3;
    localparam int CPC_FUNC_BIT = 0;
    localparam int CPC_OUT_SEL_BIT = 1;
    localparam int EPE_ENABLE_BIT = 0;
    localparam int EPE_BOTH_BIT = 1;
    localparam int EPE_POL_BIT = 2;
    // -----------------------------
    // reset values and counts
    // -----------------------------
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [7:0] TIMER_RESET = 8'h00;
    localparam int PRE_DIV_LOW = 4;
    localparam int PRE_DIV_HIGH = 16;
    // timer 2 count source codes
    typedef enum logic [1:0] {
        DRT_SRC_T1_UF = 2'b00,
        DRT_SRC_PRESCALER = 2'b01,
        DRT_SRC_PIN = 2'b10,
        DRT_SRC_SYSCLK = 2'b11
    } drt_src_t;
endpackage : drt_pkg

// File: verilog/drt_down_timer.sv
`timescale 1ns/1ps
// -----------------------------
// 8-bit auto-reload down counter
// -----------------------------
module drt_down_timer #(
    parameter int WIDTH = 8
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic run,
    input wire logic tick,
    input wire logic load_both,
    input wire logic load_reload,
    input wire logic [WIDTH-1:0] load_value,
    output logic [WIDTH-1:0] count,
    output logic underflow
);
    import drt_pkg::*;

    if (WIDTH < 1 || WIDTH > 16) begin : g_width_check
        $error("drt_down_timer: WIDTH out of range");
    end

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] reload_r;
    wire step = run && tick;
    wire at_zero = (count_r == '0);
    wire uf_now = step && at_zero;

    // combined load writes both, reload-only keeps the count
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            count_r <= '0;
            reload_r <= '0;
        end else begin
            if (load_both || load_reload) begin
                reload_r <= load_value;
            end
            if (load_both) begin
                count_r <= load_value;
            end else if (uf_now) begin
                count_r <= reload_r;
            end else if (step) begin
                count_r <= count_r - 1'b1; // n+1 ticks per underflow
            end
        end
    end

    assign count = count_r;
    assign underflow = uf_now;

    chk_reload_on_uf: assert property (@(posedge sys_clk) disable iff (rst)
        uf_now && !load_both && !load_reload |=> count_r == $past(reload_r))
        else $error("counter did not reload on underflow");
    chk_reload_keeps_count: assert property (@(posedge sys_clk) disable iff (rst)
        load_reload && !load_both && !step |=> count_r == $past(count_r))
        else $error("reload-only write disturbed count");
    chk_both_load: assert property (@(posedge sys_clk) disable iff (rst)
        load_both |=> count_r == $past(load_value) && reload_r == $past(load_value))
        else $error("combined load failed");
    cov_underflow: cover property (@(posedge sys_clk) disable iff (rst) uf_now);
endmodule : drt_down_timer

// File: verif/drt_pin_model.sv
`timescale 1ns/1ps
// -----------------------------
// pin side and instruction clock model
// -----------------------------
module drt_pin_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic counter_pin_out,
    input wire logic counter_pin_oe,
    output logic instr_tick,
    output logic ext_int_pin,
    output logic counter_pin_in
);
    logic counter_pin_drv = 1'b1;

    initial ext_int_pin = 1'b1;

    // instruction clock enable, high one cycle in two
    always_ff @(posedge sys_clk) begin
        instr_tick <= rst ? 1'b0 : ~instr_tick;
    end

    // shared line: the block wins while it drives, else the outside level
    assign counter_pin_in = counter_pin_oe ? counter_pin_out : counter_pin_drv;

    // int pin level change, launched just after an edge
    task set_int(input logic lvl);
        @(posedge sys_clk);
        ext_int_pin <= lvl;
    endtask : set_int

    // pulses kept wide so the pin synchroniser cannot miss them
    task counter_pin_pulses(input int cnt);
        repeat (cnt) begin
            @(posedge sys_clk);
            counter_pin_drv <= 1'b0;
            repeat (4) @(posedge sys_clk);
            counter_pin_drv <= 1'b1;
            repeat (3) @(posedge sys_clk);
        end
    endtask : counter_pin_pulses
endmodule : drt_pin_model

// File: verif/drt_timer_block_test.sv
`timescale 1ns/1ps
module drt_timer_block_test;
    import drt_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] ops = 16'h0000;
    logic [3:0] acc_in = 4'h0;
    logic [7:0] ab_in = 8'h00;
    logic [1:0] irq_sel = 2'b00;
    logic instr_tick, ext_int_pin, counter_pin_in, counter_pin_out, counter_pin_oe;
    logic [3:0] acc_out;
    logic [7:0] ab_out;
    logic skip_taken, flag1, flag2, pre_clk;
    logic [7:0] v;
    int err_count = 0;
    int cmp_count = 0;
    int n;

    always #2.5 sys_clk = ~sys_clk;

    // op index: 0-3 writes, 4-6 reads, 7-11 timer loads/reads, 12-15 skips/accepts
    drt_timer_block #(.WIDTH(8)) drt_timer_block_i (
        .sys_clk(sys_clk), .rst(rst), .instr_tick(instr_tick), .acc_in(acc_in), .ab_in(ab_in),
        .write_prescaler_ctrl_op(ops[0]), .write_second_ctrl_op(ops[1]),
        .write_pin_ctrl_op(ops[2]), .write_ext_edge_op(ops[3]),
        .read_prescaler_ctrl_op(ops[4]), .read_second_ctrl_op(ops[5]),
        .read_pin_ctrl_op(ops[6]), .load_first_timer_op(ops[7]),
        .load_first_reload_op(ops[8]), .read_first_timer_op(ops[9]),
        .load_second_timer_op(ops[10]), .read_second_timer_op(ops[11]),
        .skip_on_first_flag_op(ops[12]), .skip_on_second_flag_op(ops[13]),
        .irq_select_control(irq_sel), .first_irq_accept(ops[14]), .second_irq_accept(ops[15]),
        .ext_int_pin(ext_int_pin), .counter_pin_in(counter_pin_in),
        .counter_pin_out(counter_pin_out), .counter_pin_oe(counter_pin_oe),
        .acc_out(acc_out), .ab_out(ab_out), .skip_taken(skip_taken),
        .first_timer_irq_flag(flag1), .second_timer_irq_flag(flag2), .prescaler_out_clk(pre_clk)
    );

    drt_pin_model drt_pin_model_i (
        .sys_clk(sys_clk), .rst(rst), .counter_pin_out(counter_pin_out),
        .counter_pin_oe(counter_pin_oe), .instr_tick(instr_tick), .ext_int_pin(ext_int_pin),
        .counter_pin_in(counter_pin_in)
    );

    // -----------------------------
    // shared tasks
    // -----------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one-cycle instruction pulse; returns just after the taking edge settles
    task op(input int i, input logic [7:0] d);
        @(posedge sys_clk);
        ops <= 16'h0001 << i;
        acc_in <= d[3:0];
        ab_in <= d;
        @(posedge sys_clk);
        ops <= 16'h0000;
        #1;
    endtask : op

    task rd(input int i, output logic [7:0] q);
        op(i, 8'h00);
        q = (i < 9) ? {4'h0, acc_out} : ab_out;
    endtask : rd

    // cycles between two toggles of the counter pin output, bounded
    task per(output int c);
        logic last;
        int k;
        k = 0;
        last = counter_pin_out;
        while (counter_pin_out === last && k < 5000) begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        c = 0;
        last = counter_pin_out;
        while (counter_pin_out === last && c < 5000) begin
            @(posedge sys_clk);
            #1;
            c++;
        end
    endtask : per

    // counts toggles of the pin output (0) or prescaler clock (1)
    task tog(input bit which, input int cyc, output int cnt);
        logic last;
        cnt = 0;
        last = which ? pre_clk : counter_pin_out;
        repeat (cyc) begin
            @(posedge sys_clk);
            #1;
            if ((which ? pre_clk : counter_pin_out) !== last) cnt++;
            last = which ? pre_clk : counter_pin_out;
        end
    endtask : tog

    // -----------------------------
    // scenarios
    // -----------------------------
    task sc_regs;
        int i;
        for (i = 0; i < 3; i++) begin
            rd(4 + i, v);
            check(v, 8'h00);
            op(i, 8'(i * 3 + 4));
            rd(4 + i, v);
            check(v, 8'(i * 3 + 4));
            op(i, 8'h00);
        end
        check({7'h0, counter_pin_oe}, 8'h00);
    endtask : sc_regs

    // stopped loads, then reload-only write while counting from the old value
    task sc_load;
        op(0, 8'h00);
        op(7, 8'h5a);
        rd(9, v);
        check(v, 8'h5a);
        op(10, 8'ha5);
        rd(11, v);
        check(v, 8'ha5);
        op(7, 8'h02);
        op(8, 8'h05);
        rd(9, v);
        check(v, 8'h02);
        op(2, 8'h01);
        op(0, 8'h0a);
        check(counter_pin_oe, 1'b1);
        per(n);
        check(n, 48);
        check(flag1, 1'b1);
        // reload-only write just after an underflow, well clear of the next one
        op(8, 8'h01);
        tog(0, 40, n);
        check(n, 0);
        per(n);
        check(n, 16);
    endtask : sc_load

    // ratio and count boundaries: cycles = (n+1) * ratio * 2
    task automatic sc_ratio;
        logic [7:0] nv [3] = '{8'h02, 8'h00, 8'hff};
        logic [7:0] pv [3] = '{8'h0a, 8'h0e, 8'h0a};
        int ex [3] = '{24, 32, 2048};
        int i;
        op(2, 8'h01);
        for (i = 0; i < 3; i++) begin
            op(0, 8'h00);
            op(7, nv[i]);
            op(0, pv[i]);
            per(n);
            check(n, ex[i]);
        end
    endtask : sc_ratio

    // timer 2 sources other than the pin, reload value 1
    task automatic sc_t2;
        logic [7:0] src [3] = '{8'h03, 8'h01, 8'h00};
        int ex [3] = '{4, 16, 16};
        int i;
        op(2, 8'h03);
        op(0, 8'h00);
        op(7, 8'h00);
        op(0, 8'h0a);
        for (i = 0; i < 3; i++) begin
            op(1, 8'h00);
            op(10, 8'h01);
            op(1, src[i]);
            op(1, src[i] | 8'h08);
            per(n);
            check(n, ex[i]);
        end
        check(flag2, 1'b1);
    endtask : sc_t2

    // five falling pin edges from 3: 2,1,0,reload 3,2
    task sc_pin;
        op(2, 8'h00);
        op(1, 8'h00);
        op(15, 8'h00);
        check(flag2, 1'b0);
        op(10, 8'h03);
        op(1, 8'h02);
        op(1, 8'h0a);
        drt_pin_model_i.counter_pin_pulses(5);
        repeat (8) @(posedge sys_clk);
        op(1, 8'h02);
        rd(11, v);
        check(v, 8'h02);
        check(flag2, 1'b1);
    endtask : sc_pin

    // skip clears only when selected; accept clears otherwise
    task sc_flags;
        op(0, 8'h00);
        op(14, 8'h00);
        check(flag1, 1'b0);
        op(7, 8'h00);
        op(0, 8'h0a);
        repeat (40) @(posedge sys_clk);
        op(0, 8'h08);
        check(flag1, 1'b1);
        op(12, 8'h00);
        check({skip_taken, flag1}, 2'b01);
        op(14, 8'h00);
        check(flag1, 1'b0);
        op(0, 8'h0a);
        repeat (40) @(posedge sys_clk);
        op(0, 8'h08);
        @(posedge sys_clk);
        irq_sel <= 2'b01;
        op(12, 8'h00);
        check({skip_taken, flag1}, 2'b10);
        op(12, 8'h00);
        check({skip_taken, flag1}, 2'b00);
        @(posedge sys_clk);
        irq_sel <= 2'b11;
        op(13, 8'h00);
        check({skip_taken, flag2}, 2'b10);
    endtask : sc_flags

    // each edge mode with auto-stop: wrong edge idle (both-edge mode takes either edge), right edge one underflow
    task automatic sc_sync;
        logic [7:0] md [3] = '{8'h01, 8'h05, 8'h03};
        logic lv [3] = '{1'b0, 1'b1, 1'b0};
        int e1 [3] = '{0, 0, 1};
        int i;
        op(0, 8'h00);
        op(7, 8'h00);
        op(1, 8'h04);
        op(2, 8'h01);
        op(0, 8'h0b);
        for (i = 0; i < 3; i++) begin
            drt_pin_model_i.set_int(lv[i]);
            op(3, 8'h00);
            op(3, md[i]);
            tog(0, 30, n);
            drt_pin_model_i.set_int(~lv[i]);
            tog(0, 150, n);
            check(n, e1[i]);
            drt_pin_model_i.set_int(lv[i]);
            tog(0, 150, n);
            check(n, 1);
        end
        op(1, 8'h00);
        drt_pin_model_i.set_int(1'b1);
        tog(0, 150, n);
        check(16'(n > 10), 16'h1);
    endtask : sc_sync

    task sc_pre;
        op(0, 8'h08);
        tog(1, 40, n);
        check(n, 10);
        op(0, 8'h00);
        // the stop lands one edge after the write, let the clear settle first
        repeat (2) @(posedge sys_clk);
        tog(1, 40, n);
        check(n, 0);
        check(pre_clk, 1'b0);
    endtask : sc_pre

    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : finish_test

    // -----------------------------
    // main sequence and watchdog
    // -----------------------------
    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        sc_regs;
        sc_load;
        sc_ratio;
        sc_t2;
        sc_pin;
        sc_flags;
        sc_sync;
        sc_pre;
        finish_test;
    end

    // the whole run needs well under a fifth of this span
    initial begin
        #400000;
        err_count++;
        finish_test;
    end
endmodule : drt_timer_block_test
